// ==== design/atd_decode.sv ====
// Execution of the wakeup transfers and the store-with-pointer-modify instruction
// Functional notes
// - The first wakeup transfer copies all four accumulator bits into wakeup_ctrl_one.
// - The second wakeup transfer loads the accumulator into wakeup_ctrl_two in one cycle.
// - Opcode 10_0000_1010 copies the accumulator into wakeup_ctrl_three in one cycle.
// - The store writes the accumulator at the data pointer as it was before the update.
// - The same store replaces the pointer X field by X XOR the four-bit immediate.
`timescale 1ns/1ps
`default_nettype none
module atd_decode
   import atd_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire atd_instr_t  instr,
   input  wire logic [3:0]  acc,
   input  wire atd_dp_t     data_pointer,
   input  wire logic [7:0]  ram_rd_addr,
   output logic [3:0]       ram_rd_data,
   output logic [3:0]       wakeup_ctrl_one,
   output logic [3:0]       wakeup_ctrl_two,
   output logic [3:0]       wakeup_ctrl_three,
   output logic [3:0]       dp_x_new,
   output logic             dp_x_we,
   output logic             exec_done,
   output logic             skip_next,
   output logic             carry_flag_we
);

   atd_state_t  st_q;
   atd_state_t  st_d;
   atd_ram_wr_t ram_wr;
   logic        hit_wk1;
   logic        hit_wk2;
   logic        hit_wk3;
   logic        hit_stx;

   // Decode is purely combinational on the fetched word
   always_comb
   begin
      hit_wk1 = instr.valid && (instr.word == ATD_OP_WK1);
      hit_wk2 = instr.valid && (instr.word == ATD_OP_WK2);
      hit_wk3 = instr.valid && (instr.word == ATD_OP_WK3);
      hit_stx = instr.valid && (instr.word[ATD_IW-1:ATD_OPC_LSB] == ATD_OP_STX);
   end

   // Old pointer addresses the write; the new X only lands at the edge
   always_comb
   begin
      ram_wr.we   = hit_stx;
      ram_wr.addr = {data_pointer.x, data_pointer.y};
      ram_wr.data = acc;
   end

   always_comb
   begin
      st_d          = st_q;
      st_d.dpx_we   = 1'b0;
      st_d.done     = hit_wk1 | hit_wk2 | hit_wk3 | hit_stx;
      // Carry and skip never asserted by this group
      st_d.skip     = 1'b0;
      st_d.carry_we = 1'b0;
      if (hit_wk1)
      begin
         st_d.wk1 = acc;
      end
      if (hit_wk2)
      begin
         st_d.wk2 = acc;
      end
      if (hit_wk3)
      begin
         st_d.wk3 = acc;
      end
      if (hit_stx)
      begin
         st_d.dpx    = data_pointer.x ^ instr.word[ATD_NW-1:0];
         st_d.dpx_we = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q          <= '0;
         st_q.wk1      <= ATD_WK_RST;
         st_q.wk2      <= ATD_WK_RST;
         st_q.wk3      <= ATD_WK_RST;
         st_q.dpx      <= ATD_DPX_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   atd_ram u_ram
   (
      .mclk    (mclk),
      .nrst    (nrst),
      .wr      (ram_wr),
      .rd_addr (ram_rd_addr),
      .rd_data (ram_rd_data)
   );

   assign wakeup_ctrl_one   = st_q.wk1;
   assign wakeup_ctrl_two   = st_q.wk2;
   assign wakeup_ctrl_three = st_q.wk3;
   assign dp_x_new          = st_q.dpx;
   assign dp_x_we           = st_q.dpx_we;
   assign exec_done         = st_q.done;
   assign skip_next         = st_q.skip;
   assign carry_flag_we     = st_q.carry_we;

   // Assertions
   sequence s_wk1_issue;
      instr.valid && instr.word == ATD_OP_WK1;
   endsequence

   sequence s_stx_issue;
      instr.valid && instr.word[9:4] == ATD_OP_STX;
   endsequence

   sequence s_wk2_issue;
      instr.valid && instr.word == ATD_OP_WK2;
   endsequence

   sequence s_wk3_issue;
      instr.valid && instr.word == ATD_OP_WK3;
   endsequence

   sequence s_any_issue;
      s_wk1_issue or s_wk2_issue or s_wk3_issue or s_stx_issue;
   endsequence

   AST_WK1_COPY: assert property (@(posedge mclk) disable iff (!nrst)
      s_wk1_issue |=> wakeup_ctrl_one == $past(acc))
      else $error("wakeup_ctrl_one did not take the accumulator");

   AST_WK1_ONLY: assert property (@(posedge mclk) disable iff (!nrst)
      s_wk1_issue |=> $stable(wakeup_ctrl_two) && $stable(wakeup_ctrl_three))
      else $error("first wakeup transfer disturbed another register");

   AST_WK2_COPY: assert property (@(posedge mclk) disable iff (!nrst)
      instr.valid && instr.word == ATD_OP_WK2 |=> wakeup_ctrl_two == $past(acc) && exec_done)
      else $error("wakeup_ctrl_two did not take the accumulator");

   AST_WK3_COPY: assert property (@(posedge mclk) disable iff (!nrst)
      s_wk3_issue |=> wakeup_ctrl_three == $past(acc))
      else $error("wakeup_ctrl_three did not take the accumulator");

   AST_WK3_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
      !(instr.valid && instr.word == ATD_OP_WK3) |=> $stable(wakeup_ctrl_three))
      else $error("wakeup_ctrl_three changed without its transfer");

   // Read port lags by a register, so the address must hold one more edge
   AST_STX_STORE: assert property (@(posedge mclk) disable iff (!nrst)
      s_stx_issue ##0 (ram_rd_addr == {data_pointer.x, data_pointer.y})
      ##1 $stable(ram_rd_addr)
      |=> ram_rd_data == $past(acc, 2))
      else $error("store did not land at the old pointer");

   AST_STX_XOR: assert property (@(posedge mclk) disable iff (!nrst)
      s_stx_issue |=> dp_x_we && dp_x_new == ($past(data_pointer.x) ^ $past(instr.word[3:0])))
      else $error("pointer X field not updated by XOR");

   AST_XWE_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
      dp_x_we |-> $past(instr.valid) && $past(instr.word[9:4]) == ATD_OP_STX)
      else $error("pointer X write without a store");

   AST_NO_CY_SKIP: assert property (@(posedge mclk) disable iff (!nrst)
      exec_done |-> !skip_next && !carry_flag_we)
      else $error("transfer touched carry or skip");

   AST_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!nrst)
      s_any_issue |=> exec_done)
      else $error("transfer not done in one cycle");

   // A stuck done would hide a hang in the core
   AST_DONE_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
      exec_done |-> $past(instr.valid) &&
         ($past(instr.word) == ATD_OP_WK1 || $past(instr.word) == ATD_OP_WK2 ||
          $past(instr.word) == ATD_OP_WK3 || $past(instr.word[9:4]) == ATD_OP_STX))
      else $error("exec_done without a decoded transfer");

   AST_SKIP_NEVER: assert property (@(posedge mclk) disable iff (!nrst)
      !skip_next && !carry_flag_we)
      else $error("skip or carry write raised");

   // Hold checks catch a decoder that also fires on neighbouring codes
   AST_WK1_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
      !(instr.valid && instr.word == ATD_OP_WK1) |=> $stable(wakeup_ctrl_one))
      else $error("wakeup_ctrl_one changed without its transfer");

   AST_WK2_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
      !(instr.valid && instr.word == ATD_OP_WK2) |=> $stable(wakeup_ctrl_two))
      else $error("wakeup_ctrl_two changed without its transfer");

   AST_WK2_ONLY: assert property (@(posedge mclk) disable iff (!nrst)
      s_wk2_issue |=> $stable(wakeup_ctrl_one) && $stable(wakeup_ctrl_three))
      else $error("second wakeup transfer disturbed another register");

   AST_WK3_ONLY: assert property (@(posedge mclk) disable iff (!nrst)
      s_wk3_issue |=> $stable(wakeup_ctrl_one) && $stable(wakeup_ctrl_two))
      else $error("third wakeup transfer disturbed another register");

   AST_STX_KEEP_WK: assert property (@(posedge mclk) disable iff (!nrst)
      s_stx_issue |=> $stable(wakeup_ctrl_one) && $stable(wakeup_ctrl_two)
         && $stable(wakeup_ctrl_three))
      else $error("store disturbed a wakeup register");

   // The core loads X on every pulse, so a stray pulse corrupts the pointer
   AST_DPX_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
      !(instr.valid && instr.word[9:4] == ATD_OP_STX) |=> $stable(dp_x_new) && !dp_x_we)
      else $error("pointer X output moved without a store");

   AST_XWE_DONE: assert property (@(posedge mclk) disable iff (!nrst)
      dp_x_we |-> exec_done)
      else $error("pointer X write outside a completed store");

endmodule // atd_decode
`default_nettype wire

// ==== design/atd_pkg.sv ====
// Shared constants and carrier types for the accumulator transfer decoder
package atd_pkg;

   localparam int          ATD_IW       = 10;
   localparam int          ATD_NW       = 4;
   localparam int          ATD_AW       = 8;
   localparam int          ATD_DEPTH    = 256;
   // Full ten-bit opcodes of the wakeup transfers
   localparam logic [9:0]  ATD_OP_WK1   = 10'h214;
   localparam logic [9:0]  ATD_OP_WK2   = 10'h215;
   localparam logic [9:0]  ATD_OP_WK3   = 10'h20A;
   // Store-and-modify: upper six bits fixed, low four are the immediate
   localparam logic [5:0]  ATD_OP_STX   = 6'h2B;
   localparam int          ATD_OPC_LSB  = 4;
   localparam logic [3:0]  ATD_WK_RST   = 4'h0;
   localparam logic [3:0]  ATD_DPX_RST  = 4'h0;

   typedef struct packed {
      logic       valid;
      logic [9:0] word;
   } atd_instr_t;

   typedef struct packed {
      logic [3:0] x;
      logic [3:0] y;
   } atd_dp_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [3:0] data;
   } atd_ram_wr_t;

   typedef struct packed {
      logic [3:0] wk1;
      logic [3:0] wk2;
      logic [3:0] wk3;
      logic [3:0] dpx;
      logic       dpx_we;
      logic       done;
      logic       skip;
      logic       carry_we;
   } atd_state_t;

endpackage

// ==== design/atd_ram.sv ====
// Data memory of nibbles with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module atd_ram
   import atd_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire atd_ram_wr_t wr,
   input  wire logic [7:0]  rd_addr,
   output logic [3:0]       rd_data
);

   logic [3:0] mem_q [ATD_DEPTH];
   logic [3:0] rd_q;

   // No reset on the array; contents are undefined until written
   always_ff @(posedge mclk)
   begin
      if (wr.we)
      begin
         mem_q[wr.addr] <= wr.data;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_q <= 4'h0;
      end
      else
      begin
         rd_q <= mem_q[rd_addr];
      end
   end

   assign rd_data = rd_q;

endmodule // atd_ram
`default_nettype wire

// ==== dv/atd_fetch_model.sv ====
// Core-side model that owns the data pointer
`timescale 1ns/1ps
`default_nettype none
module atd_fetch_model
   import atd_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [3:0] dp_x_new,
   input  wire logic       dp_x_we,
   output var atd_dp_t     data_pointer
);
   // X moves only on the pulse, so a stale pointer shows up as a bad address
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         data_pointer <= '0;
      else if (dp_x_we)
         data_pointer.x <= dp_x_new;
   end
   task automatic set_dp(input atd_dp_t v);
      data_pointer = v;
   endtask
endmodule // atd_fetch_model
`default_nettype wire

// ==== dv/test_atd_decode.sv ====
// Self-checking bench for the transfer decoder
`timescale 1ns/1ps
`default_nettype none
module test_atd_decode;
   import atd_pkg::*;
   logic       mclk, nrst, dp_x_we, exec_done, skip_next, carry_flag_we;
   atd_instr_t instr;
   atd_dp_t    data_pointer;
   logic [3:0] acc, ram_rd_data, dp_x_new, wk1, wk2, wk3;
   logic [7:0] ram_rd_addr;
   logic [3:0] mem [256];
   int         num_errors, n_compared, cyc;
   atd_decode atd_decode_i (.mclk(mclk), .nrst(nrst), .instr(instr), .acc(acc),
      .data_pointer(data_pointer), .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data),
      .wakeup_ctrl_one(wk1), .wakeup_ctrl_two(wk2), .wakeup_ctrl_three(wk3),
      .dp_x_new(dp_x_new), .dp_x_we(dp_x_we), .exec_done(exec_done),
      .skip_next(skip_next), .carry_flag_we(carry_flag_we));
   atd_fetch_model atd_fetch_model_i (.mclk(mclk), .nrst(nrst), .dp_x_new(dp_x_new),
      .dp_x_we(dp_x_we), .data_pointer(data_pointer));
   always #4 mclk = ~mclk;
   task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Hold each word one cycle, then look after the answering edge
   task automatic issue(input logic [9:0] w, input logic [3:0] a);
      @(posedge mclk);
      #1 instr = '{valid: 1'b1, word: w};
      acc = a;
      @(posedge mclk);
      #1 instr.valid = 1'b0;
   endtask
   task automatic side(input logic d);
      chk("done", {3'h0, d}, {3'h0, exec_done});
      chk("skip", 4'h0, {3'h0, skip_next});
      chk("carry", 4'h0, {3'h0, carry_flag_we});
   endtask
   task automatic t_wakeup();
      issue(ATD_OP_WK1, 4'hA);
      chk("wk1", 4'hA, wk1);
      side(1'b1);
      issue(ATD_OP_WK2, 4'h5);
      chk("wk2", 4'h5, wk2);
      chk("wk1", 4'hA, wk1);
      side(1'b1);
      issue(ATD_OP_WK3, 4'hC);
      chk("wk3", 4'hC, wk3);
      side(1'b1);
      @(posedge mclk);
      #1 side(1'b0);
   endtask
   // Neighbouring codes must leave every register alone
   task automatic t_refuse();
      issue(10'h20B, 4'h3);
      chk("wk3", 4'hC, wk3);
      side(1'b0);
      issue(10'h216, 4'h3);
      chk("wk2", 4'h5, wk2);
      chk("dpwe", 4'h0, {3'h0, dp_x_we});
      side(1'b0);
   endtask
   task automatic t_store();
      atd_dp_t p;
      logic [7:0] q [$];
      p = '{x: 4'h3, y: 4'h2};
      atd_fetch_model_i.set_dp(p);
      for (int j = 0; j < 16; j++)
      begin
         ram_rd_addr = {p.x, p.y};
         mem[{p.x, p.y}] = 4'(15 - j);
         q.push_back({p.x, p.y});
         issue({ATD_OP_STX, 4'(j)}, 4'(15 - j));
         chk("dpx", p.x ^ 4'(j), dp_x_new);
         chk("dpwe", 4'h1, {3'h0, dp_x_we});
         side(1'b1);
         @(posedge mclk);
         #1 chk("ram_old_dp", 4'(15 - j), ram_rd_data);
         p.x = p.x ^ 4'(j);
      end
      foreach (q[i])
      begin
         @(posedge mclk);
         #1 ram_rd_addr = q[i];
         @(posedge mclk);
         #1 chk("ram", mem[q[i]], ram_rd_data);
      end
   endtask
   // Mid-run reset clears every register but the RAM array; first transfer right after release
   task automatic t_reset();
      @(posedge mclk);
      #1 nrst = 1'b0;
      #1 chk("wk1", ATD_WK_RST, wk1);
      chk("wk2", ATD_WK_RST, wk2);
      chk("wk3", ATD_WK_RST, wk3);
      chk("dpx", ATD_DPX_RST, dp_x_new);
      chk("dpwe", 4'h0, {3'h0, dp_x_we});
      chk("ram", 4'h0, ram_rd_data);
      side(1'b0);
      repeat (2) @(posedge mclk);
      #1 nrst = 1'b1;
      issue(ATD_OP_WK1, 4'h7);
      chk("wk1", 4'h7, wk1);
      chk("wk2", ATD_WK_RST, wk2);
      side(1'b1);
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         num_errors++;
         final_report();
      end
   end
   initial
   begin
      mclk = 0;
      nrst = 0;
      instr = '0;
      acc = '0;
      ram_rd_addr = '0;
      repeat (3) @(posedge mclk);
      #1 nrst = 1;
      t_wakeup();
      t_refuse();
      t_store();
      t_reset();
      final_report();
   end
endmodule // test_atd_decode
`default_nettype wire
